// [hdl/power_ctrl_pkg.sv]
// ===========================================================
// register map, field positions, reset values, timing
package power_ctrl_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] OFS_CTRL_LOW = 8'h00;
  localparam logic [7:0] OFS_CTRL_HIGH = 8'h04;
  localparam logic [7:0] OFS_WAKE_LOW = 8'h08;
  localparam logic [7:0] OFS_WAKE_HIGH = 8'h0C;
  localparam logic [7:0] OFS_RESET_CTRL_THREE = 8'h10;
  localparam logic [7:0] OFS_RESET_CTRL_FOUR = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;
  localparam logic [7:0] OFS_PIN_DIR = 8'h1C;
  localparam logic [7:0] OFS_OUT_LATCH = 8'h20;
  localparam logic [7:0] OFS_SCRATCH0 = 8'h30;
  // field positions
  localparam int BIT_HOLD = 0;
  localparam int BIT_BOR_STAT = 1;
  localparam int BIT_ARM = 7;
  localparam int BIT_WAKE_BOR = 6;
  localparam int BIT_WAKE_WDT = 4;
  localparam int BIT_WAKE_CAL = 3;
  localparam int BIT_WAKE_MASTER_CLEAR_PIN = 2;
  localparam int BIT_WAKE_EXT = 0;
  localparam int BIT_BK_EXIT = 0;
  localparam int BIT_BK_LOST = 1;
  localparam int BIT_REG_KEEP = 0;
  localparam int BIT_DS_EXIT = 2;
  localparam int BIT_SRET = 4;
  localparam int CFG_RET = 0;
  localparam int CFG_BOR_EN = 3;
  localparam int CFG_WDT_EN = 4;
  localparam int CFG_WDT_CLK = 5;
  localparam int CFG_CAL_LO = 6;
  localparam int CFG_PS_LO = 8;
  localparam int CFG_INTERRUPT_PRIORITY_ENABLE = 13;
  localparam int CFG_OSC_LO = 14;
  // reset values
  localparam logic [7:0] RST_PIN_DIR = 8'hFF;
  localparam logic [7:0] RST_OUT_LATCH = 8'h00;
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic RST_BK_LOST = 1'b1;
  // oscillator modes in the config field
  localparam logic [1:0] OSC_EXT = 2'h0;
  localparam logic [1:0] OSC_XTAL = 2'h1;
  localparam logic [1:0] OSC_PLL = 2'h2;
  localparam logic [1:0] OSC_XTAL_PLL = 2'h3;
  // watchdog: time-out when counter bit (postscale + base) sets
  localparam logic [5:0] WDT_BASE_SHIFT = 6'h06;
  // timing, all least times, rounded up
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_DS_WAKE_NS = 1000;
  localparam int T_PLL_LOCK_NS = 2000;
  localparam int T_RET_STARTUP_NS = 500;
  localparam int T_PROG_MEM_NS = 300;
  localparam int OST_PERIODS = 1024;
  localparam int OSC_PERIOD_NS = 40;
  localparam logic [15:0] DS_WAKE_CYC = 16'((T_DS_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PLL_LOCK_CYC = 16'((T_PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RET_START_CYC =
    16'((T_RET_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PROG_MEM_CYC = 16'((T_PROG_MEM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] OST_CYC =
    16'((OST_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {ST_RUN, ST_DEEP, ST_WAKE, ST_BACKUP} pwr_state_t;
endpackage

// [hdl/deep_sleep_backup_power_ctrl.sv]
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - in deep sleep inputs stay floating, outputs drive the latch level caught at entry
// - after wake pins stay held; direction and latch reset on plain wake, new values wait
// - clearing the hold bit hands pins to direction and latch registers
// - brown-out or supply loss releases pins and drops scratch unless battery present
// - master clear in deep sleep releases pins and keeps scratch contents
// - watchdog enabled by a config bit, five-bit postscale sets time-out
// - entering deep sleep clears the watchdog counter
// - config bit picks the watchdog clock, low-power RC or secondary oscillator
// - enabled watchdog starts its selected clock on entry
// - enabled brown-out in deep sleep does not wake the device
// - wake-source bit 6 tells whether a brown-out happened during sleep
// - calendar alarm wakes the device; two-bit field selects its clock
// - retention mode needs arm, retention config 0 and software bit 1
// - plain wake waits wake delay plus crystal start-up and/or PLL lock as the oscillator mode needs
// - retention wake waits regulator start-up when keep bit 0, plus memory delay when priority bit 0
// - regulator-keep bit holds the regulator active while asleep
// - supply loss enters backup mode, retention regulator kept alive
// - supply return resets registers except config, scratch and flags, like power-on
// - backup-exit flag sets on return from backup with battery good, stays until cleared
// - backup-lost flag sets on no battery, battery sag or first power-up
// - entering deep sleep clears both wake-source registers
module deep_sleep_backup_power_ctrl (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SLEEP_EXEC,
  input wire logic VDD_GOOD,
  input wire logic VBAT_GOOD,
  input wire logic DS_BROWNOUT_TRIP,
  input wire logic MASTER_CLEAR,
  input wire logic CAL_ALARM,
  input wire logic EXT_WAKE,
  input wire logic LOW_POWER_RC_OSC_TICK,
  input wire logic SECONDARY_OSC_TICK,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output logic DEEP_SLEEP,
  output logic RET_REG_EN,
  output logic REG_KEEP,
  output logic CORE_HOLD,
  output logic BACKUP_MODE,
  output logic LOW_POWER_RC_OSC_START,
  output logic SECONDARY_OSC_START,
  output logic [1:0] CAL_CLK_SEL
);
  // ===========================================================
  // reset release
  logic rst_meta_r;
  logic rst_n_r;

  // two stages so release never lands mid-cycle for the rest of the block
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ===========================================================
  // declarations and decode
  function automatic logic is_scratch(input logic [7:0] a);
    return (a[7:4] == power_ctrl_pkg::OFS_SCRATCH0[7:4]) && (a[1:0] == 2'h0);
  endfunction

  power_ctrl_pkg::pwr_state_t state_r;
  logic ack_r, hold_r, bor_seen_r, arm_pend_r, arm_r, ret_mode_r;
  logic bk_exit_r, bk_lost_r, reg_keep_r, sret_r, ds_exit_r;
  logic [3:0] wake_src_r;
  logic [15:0] cfg_r, dly_r;
  logic [7:0] dir_r, lat_r, held_dir_r, held_lat_r;
  logic [7:0] scratch_r [4];
  logic [3:0] scr_pend_r;
  logic [37:0] wdt_cnt_r;
  logic [31:0] rd_nxt;
  logic wb_req, wr_lo, wr_hi, in_deep, enter, bor_ev, wdt_to, wake_ev;
  logic vdd_loss, vdd_back, sys_por, scr_lost, wdt_tick;
  logic [5:0] wdt_bit;

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr_lo = wb_req & WB_WE_I & WB_SEL_I[0];
  assign wr_hi = wb_req & WB_WE_I & WB_SEL_I[1];
  assign in_deep = (state_r == power_ctrl_pkg::ST_DEEP);
  // sleep instruction with arm set; otherwise ordinary sleep, not ours
  assign enter = (state_r == power_ctrl_pkg::ST_RUN) & SLEEP_EXEC & arm_r & VDD_GOOD;
  assign bor_ev = in_deep & DS_BROWNOUT_TRIP & cfg_r[power_ctrl_pkg::CFG_BOR_EN];
  assign wdt_tick = cfg_r[power_ctrl_pkg::CFG_WDT_CLK] ? SECONDARY_OSC_TICK : LOW_POWER_RC_OSC_TICK;
  assign wdt_bit = 6'(cfg_r[power_ctrl_pkg::CFG_PS_LO +: 5]) + power_ctrl_pkg::WDT_BASE_SHIFT;
  assign wdt_to = cfg_r[power_ctrl_pkg::CFG_WDT_EN] & wdt_cnt_r[wdt_bit];
  // brown-out alone is not a wake source
  assign wake_ev = in_deep & VDD_GOOD & (MASTER_CLEAR | CAL_ALARM | EXT_WAKE | wdt_to);
  assign vdd_loss = ~VDD_GOOD & (state_r != power_ctrl_pkg::ST_BACKUP);
  assign vdd_back = VDD_GOOD & (state_r == power_ctrl_pkg::ST_BACKUP);
  // plain deep-sleep wake and supply return both act as a power-on reset
  assign sys_por = (wake_ev & ~ret_mode_r) | vdd_back;
  assign scr_lost = ~VBAT_GOOD & (bor_ev | vdd_loss | (state_r == power_ctrl_pkg::ST_BACKUP));

  // exit delay per mode and oscillator
  function automatic logic [15:0] exit_delay(input logic ret, input logic keep,
                                             input logic interrupt_priority_enable, input logic [1:0] osc);
    logic [15:0] d;
    d = power_ctrl_pkg::DS_WAKE_CYC;
    if (ret)
    begin
      d = 16'h0000;
      if (!keep)
        d = d + power_ctrl_pkg::RET_START_CYC;
      if (!interrupt_priority_enable)
        d = d + power_ctrl_pkg::PROG_MEM_CYC;
    end
    case (osc)
      power_ctrl_pkg::OSC_XTAL: d = d + power_ctrl_pkg::OST_CYC;
      power_ctrl_pkg::OSC_PLL: d = d + power_ctrl_pkg::PLL_LOCK_CYC;
      power_ctrl_pkg::OSC_XTAL_PLL: d = d + power_ctrl_pkg::OST_CYC + power_ctrl_pkg::PLL_LOCK_CYC;
      default: d = d;
    endcase
    return d;
  endfunction

  // ===========================================================
  // power state sequence
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= power_ctrl_pkg::ST_RUN;
      dly_r <= 16'h0000;
      ret_mode_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        power_ctrl_pkg::ST_RUN:
        begin
          if (vdd_loss)
            state_r <= power_ctrl_pkg::ST_BACKUP;
          else if (enter)
          begin
            state_r <= power_ctrl_pkg::ST_DEEP;
            ret_mode_r <= ~cfg_r[power_ctrl_pkg::CFG_RET] & sret_r;
          end
        end
        power_ctrl_pkg::ST_DEEP:
        begin
          if (vdd_loss)
            state_r <= power_ctrl_pkg::ST_BACKUP;
          else if (wake_ev)
          begin
            state_r <= power_ctrl_pkg::ST_WAKE;
            dly_r <= exit_delay(ret_mode_r, reg_keep_r, cfg_r[power_ctrl_pkg::CFG_INTERRUPT_PRIORITY_ENABLE],
                                cfg_r[power_ctrl_pkg::CFG_OSC_LO +: 2]);
          end
        end
        power_ctrl_pkg::ST_WAKE:
        begin
          if (vdd_loss)
            state_r <= power_ctrl_pkg::ST_BACKUP;
          else if (dly_r == 16'h0000)
            state_r <= power_ctrl_pkg::ST_RUN;
          else
            dly_r <= dly_r - 16'h0001;
        end
        power_ctrl_pkg::ST_BACKUP:
        begin
          // supply back: power-on style restart from the reset vector
          if (VDD_GOOD)
          begin
            state_r <= power_ctrl_pkg::ST_WAKE;
            ret_mode_r <= 1'b0;
            dly_r <= power_ctrl_pkg::DS_WAKE_CYC;
          end
        end
        default: state_r <= power_ctrl_pkg::ST_RUN;
      endcase
    end
  end

  // ===========================================================
  // pin hold and pin drive
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      hold_r <= 1'b0;
      held_dir_r <= power_ctrl_pkg::RST_PIN_DIR;
      held_lat_r <= power_ctrl_pkg::RST_OUT_LATCH;
    end
    else if (vdd_loss | bor_ev | (in_deep & MASTER_CLEAR))
      hold_r <= 1'b0;
    else if (enter)
    begin
      hold_r <= 1'b1;
      held_dir_r <= dir_r;
      held_lat_r <= lat_r;
    end
    else if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_CTRL_LOW && !WB_DAT_I[power_ctrl_pkg::BIT_HOLD])
      hold_r <= 1'b0;
  end

  // held copy wins over live registers; nothing driven in backup mode
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      PIN_OUT <= 8'h00;
      PIN_OE <= 8'h00;
    end
    else if (state_r == power_ctrl_pkg::ST_BACKUP)
    begin
      PIN_OUT <= 8'h00;
      PIN_OE <= 8'h00;
    end
    else
    begin
      PIN_OUT <= hold_r ? held_lat_r : lat_r;
      PIN_OE <= hold_r ? ~held_dir_r : ~dir_r;
    end
  end

  // direction and latch: reset by any power-on, held pins ignore them
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      dir_r <= power_ctrl_pkg::RST_PIN_DIR;
      lat_r <= power_ctrl_pkg::RST_OUT_LATCH;
    end
    else if (sys_por)
    begin
      dir_r <= power_ctrl_pkg::RST_PIN_DIR;
      lat_r <= power_ctrl_pkg::RST_OUT_LATCH;
    end
    else
    begin
      if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_PIN_DIR)
        dir_r <= WB_DAT_I[7:0];
      if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_OUT_LATCH)
        lat_r <= WB_DAT_I[7:0];
    end
  end

  // ===========================================================
  // arm, config and control bits
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      arm_pend_r <= 1'b0;
      arm_r <= 1'b0;
      reg_keep_r <= 1'b0;
      sret_r <= 1'b0;
      cfg_r <= power_ctrl_pkg::RST_CONFIG;
    end
    else
    begin
      if (enter | sys_por)
      begin
        arm_pend_r <= 1'b0;
        arm_r <= 1'b0;
      end
      else if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_CTRL_HIGH)
      begin
        // a lone write only half-arms, guarding against stray entry
        arm_pend_r <= WB_DAT_I[power_ctrl_pkg::BIT_ARM] & ~arm_pend_r;
        arm_r <= WB_DAT_I[power_ctrl_pkg::BIT_ARM] & (arm_pend_r | arm_r);
      end
      if (vdd_back)
      begin
        reg_keep_r <= 1'b0;
        sret_r <= 1'b0;
      end
      else if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_RESET_CTRL_FOUR)
      begin
        reg_keep_r <= WB_DAT_I[power_ctrl_pkg::BIT_REG_KEEP];
        sret_r <= WB_DAT_I[power_ctrl_pkg::BIT_SRET];
      end
      // configuration survives every reset but the first power-up
      if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_CONFIG)
        cfg_r[7:0] <= WB_DAT_I[7:0];
      if (wr_hi && WB_ADR_I == power_ctrl_pkg::OFS_CONFIG)
        cfg_r[15:8] <= WB_DAT_I[15:8];
    end
  end

  // ===========================================================
  // status flags: hardware set wins over software clear
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      bor_seen_r <= 1'b0;
      wake_src_r <= 4'h0;
      ds_exit_r <= 1'b0;
      bk_exit_r <= 1'b0;
      bk_lost_r <= power_ctrl_pkg::RST_BK_LOST;
    end
    else
    begin
      if (enter)
      begin
        bor_seen_r <= 1'b0;
        wake_src_r <= 4'h0;
      end
      else
      begin
        if (bor_ev)
          bor_seen_r <= 1'b1;
        if (wake_ev)
          wake_src_r <= wake_src_r | {EXT_WAKE, wdt_to, CAL_ALARM, MASTER_CLEAR};
      end
      if (wake_ev)
        ds_exit_r <= 1'b1;
      else if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_RESET_CTRL_FOUR)
        ds_exit_r <= ds_exit_r & WB_DAT_I[power_ctrl_pkg::BIT_DS_EXIT];
      if (vdd_back & VBAT_GOOD)
        bk_exit_r <= 1'b1;
      else if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_RESET_CTRL_THREE)
        bk_exit_r <= bk_exit_r & WB_DAT_I[power_ctrl_pkg::BIT_BK_EXIT];
      if (~VBAT_GOOD & (vdd_loss | (state_r == power_ctrl_pkg::ST_BACKUP)))
        bk_lost_r <= 1'b1;
      else if (wr_lo && WB_ADR_I == power_ctrl_pkg::OFS_RESET_CTRL_THREE)
        bk_lost_r <= bk_lost_r & WB_DAT_I[power_ctrl_pkg::BIT_BK_LOST];
    end
  end

  // ===========================================================
  // deep-sleep watchdog; counts only ticks of the selected clock
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      wdt_cnt_r <= 38'h0;
    else if (enter)
      wdt_cnt_r <= 38'h0;
    else if (in_deep & cfg_r[power_ctrl_pkg::CFG_WDT_EN] & wdt_tick)
      wdt_cnt_r <= wdt_cnt_r + 38'h1;
  end

  // ===========================================================
  // retained scratch registers, stored on the second write
  for (genvar i = 0; i < 4; i++)
  begin : g_scratch
    logic hit;
    assign hit = wr_lo && is_scratch(WB_ADR_I) && (WB_ADR_I[3:2] == 2'(i));
    always_ff @(posedge REF_CLK or negedge rst_n_r)
    begin
      if (!rst_n_r)
      begin
        scratch_r[i] <= 8'h00;
        scr_pend_r[i] <= 1'b0;
      end
      else if (scr_lost)
      begin
        scratch_r[i] <= 8'h00;
        scr_pend_r[i] <= 1'b0;
      end
      else if (hit)
      begin
        // writes need not be adjacent; pending flag waits
        if (scr_pend_r[i])
          scratch_r[i] <= WB_DAT_I[7:0];
        scr_pend_r[i] <= ~scr_pend_r[i];
      end
    end
  end

  // ===========================================================
  // register bus: one wait state, unmapped reads as zero
  always_comb
  begin
    rd_nxt = 32'h0;
    case (WB_ADR_I)
      power_ctrl_pkg::OFS_CTRL_LOW: rd_nxt[1:0] = {bor_seen_r, hold_r};
      power_ctrl_pkg::OFS_CTRL_HIGH: rd_nxt[power_ctrl_pkg::BIT_ARM] = arm_r;
      power_ctrl_pkg::OFS_WAKE_LOW: rd_nxt[6:2] = {bor_seen_r, 1'b0, wake_src_r[2:0]};
      power_ctrl_pkg::OFS_WAKE_HIGH: rd_nxt[power_ctrl_pkg::BIT_WAKE_EXT] = wake_src_r[3];
      power_ctrl_pkg::OFS_RESET_CTRL_THREE: rd_nxt[1:0] = {bk_lost_r, bk_exit_r};
      power_ctrl_pkg::OFS_RESET_CTRL_FOUR: rd_nxt[4:0] = {sret_r, 1'b0, ds_exit_r, 1'b0, reg_keep_r};
      power_ctrl_pkg::OFS_CONFIG: rd_nxt[15:0] = cfg_r;
      power_ctrl_pkg::OFS_PIN_DIR: rd_nxt[7:0] = dir_r;
      power_ctrl_pkg::OFS_OUT_LATCH: rd_nxt[7:0] = lat_r;
      default:
        if (is_scratch(WB_ADR_I))
          rd_nxt[7:0] = scratch_r[WB_ADR_I[3:2]];
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ack_r <= 1'b0;
      WB_DAT_O <= 32'h0;
    end
    else
    begin
      ack_r <= wb_req;
      if (wb_req)
        WB_DAT_O <= rd_nxt;
    end
  end
  assign WB_ACK_O = ack_r;

  // ===========================================================
  // power-control outputs, all registered
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      DEEP_SLEEP <= 1'b0;
      RET_REG_EN <= 1'b0;
      REG_KEEP <= 1'b0;
      CORE_HOLD <= 1'b0;
      BACKUP_MODE <= 1'b0;
      LOW_POWER_RC_OSC_START <= 1'b0;
      SECONDARY_OSC_START <= 1'b0;
      CAL_CLK_SEL <= 2'h0;
    end
    else
    begin
      DEEP_SLEEP <= in_deep;
      RET_REG_EN <= (in_deep & ret_mode_r) | (state_r == power_ctrl_pkg::ST_BACKUP);
      REG_KEEP <= reg_keep_r & (state_r != power_ctrl_pkg::ST_RUN);
      CORE_HOLD <= (state_r != power_ctrl_pkg::ST_RUN);
      BACKUP_MODE <= (state_r == power_ctrl_pkg::ST_BACKUP);
      // request keeps the watchdog clock running whether or not it was on
      LOW_POWER_RC_OSC_START <= in_deep & cfg_r[power_ctrl_pkg::CFG_WDT_EN] & ~cfg_r[power_ctrl_pkg::CFG_WDT_CLK];
      SECONDARY_OSC_START <= in_deep & cfg_r[power_ctrl_pkg::CFG_WDT_EN] & cfg_r[power_ctrl_pkg::CFG_WDT_CLK];
      CAL_CLK_SEL <= cfg_r[power_ctrl_pkg::CFG_CAL_LO +: 2];
    end
  end

  // ===========================================================
  // checks
  a_entry_wdt_clear: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    enter |=> (wdt_cnt_r == 38'h0)) else $error("watchdog not cleared on entry");
  a_held_pin_drive: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    hold_r && VDD_GOOD && state_r != power_ctrl_pkg::ST_BACKUP
    |=> PIN_OE == ~$past(held_dir_r) && PIN_OUT == $past(held_lat_r))
    else $error("held pins not driven from entry copy");
  a_released_pins: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    !hold_r && state_r != power_ctrl_pkg::ST_BACKUP |=> PIN_OE == ~$past(dir_r))
    else $error("released pins ignore direction");
  a_bor_release: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    bor_ev ##1 1'b1 |-> !hold_r ##1 PIN_OE == ~$past(dir_r))
    else $error("brown-out did not release pins");
  a_master_clear_pin_keep_scr: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    in_deep && MASTER_CLEAR && VDD_GOOD && !bor_ev
    |=> !hold_r && $stable(scratch_r[0]) && $stable(scratch_r[1]))
    else $error("master clear lost scratch or kept hold");
  a_bor_no_wake: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    bor_ev && !wake_ev && VDD_GOOD |=> in_deep && bor_seen_r)
    else $error("brown-out woke the device");
  a_wake_clear: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    enter |=> wake_src_r == 4'h0 && !bor_seen_r) else $error("wake sources not cleared");
  a_lost_flag: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    state_r == power_ctrl_pkg::ST_BACKUP && !VBAT_GOOD |=> bk_lost_r)
    else $error("backup-lost flag not set");
  a_ret_regulator: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
    in_deep && ret_mode_r |=> RET_REG_EN) else $error("retention regulator off");
endmodule

// [testbench/fw_master.sv]
`timescale 1ns/1ps
// ==========
// firmware model: classic single bus cycles, doubled writes where the part asks
module fw_master (
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] dat_o,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [31:0] dat
);
  initial
  begin
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    dat = 32'h0;
  end
  // hold the request until ack is sampled, then release for an idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'h1 && n < 50);
    if (n >= 50)
      tb.hang();
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  // arm bit and scratch only take on the second write
  task automatic wr2(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
    xfer(1'h1, a, d, q);
  endtask
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
// ==========
// bench: firmware model on the bus, supply and wake lines driven here
module tb;
  logic clk = 1'h0, nrst = 1'h0, slp = 1'h0, vdd = 1'h1, vbat = 1'h1, bor = 1'h0;
  logic master_clear_pin = 1'h0, alarm = 1'h0, ext = 1'h0, low_power_rc_osc = 1'h0, secondary_osc = 1'h0;
  logic cyc, stb, we, ack, ds, ret, keep, hold, bk, lst, sst;
  logic [7:0] adr, pout, poe;
  logic [31:0] dw, dr, q;
  logic [1:0] csel;
  int error_cnt = 0;
  int checked = 0;
  always #5 clk = ~clk;
  // watchdog clock ticks every second cycle, also outside deep sleep
  always @(posedge clk) low_power_rc_osc <= ~low_power_rc_osc;
  fw_master fw (.clk(clk), .ack(ack), .dat_o(dr), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .dat(dw));
  deep_sleep_backup_power_ctrl uut (.REF_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(dw),
    .WB_DAT_O(dr), .WB_ACK_O(ack), .SLEEP_EXEC(slp), .VDD_GOOD(vdd), .VBAT_GOOD(vbat),
    .DS_BROWNOUT_TRIP(bor), .MASTER_CLEAR(master_clear_pin), .CAL_ALARM(alarm), .EXT_WAKE(ext),
    .LOW_POWER_RC_OSC_TICK(low_power_rc_osc), .SECONDARY_OSC_TICK(secondary_osc), .PIN_OUT(pout), .PIN_OE(poe), .DEEP_SLEEP(ds),
    .RET_REG_EN(ret), .REG_KEEP(keep), .CORE_HOLD(hold), .BACKUP_MODE(bk),
    .LOW_POWER_RC_OSC_START(lst), .SECONDARY_OSC_START(sst), .CAL_CLK_SEL(csel));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task hang;
    error_cnt++;
    print_verdict();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    fw.xfer(1'h1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    fw.xfer(1'h0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask
  // bounded wait on deep flag (k 0) or core hold (k 1)
  task wt(input int k, input logic v, output int n);
    n = 0;
    while (((k == 0) ? ds : hold) !== v)
    begin
      @(posedge clk);
      n++;
      if (n > 6000)
        hang();
    end
  endtask
  task enter;
    int n;
    fw.wr2(8'h04, 32'h80);
    @(posedge clk);
    slp <= 1'h1;
    @(posedge clk);
    slp <= 1'h0;
    wt(0, 1'h1, n);
  endtask
  task up(output int n);
    wt(0, 1'h0, n);
    wt(1, 1'h0, n);
  endtask
  task t_pins;
    int n;
    wr(8'h18, 32'h4001);
    wr(8'h1C, 32'h0F);
    wr(8'h20, 32'hA5);
    enter();
    chk("oe", 8'hF0, poe);
    chk("out", 8'hA0, pout & poe);
    chk("ret", 1'h0, ret);
    ext <= 1'h1;
    @(posedge clk);
    ext <= 1'h0;
    up(n);
    // crystal start-up dominates the plain exit delay
    chk("xtal", 1'h1, n >= 4190 && n <= 4210);
    rd(8'h0C, 32'h1, 32'h1, "ext");
    rd(8'h1C, 32'hFF, 32'hFF, "dir");
    wr(8'h1C, 32'h00);
    chk("held", 8'hF0, poe);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge clk);
    chk("free", 8'hFF, poe);
  endtask
  task t_bor;
    int n;
    wr(8'h18, 32'h8049);
    // the select output follows the config register one cycle later
    @(posedge clk);
    chk("cal", 2'h1, csel);
    fw.wr2(8'h30, 32'h5A);
    enter();
    vbat <= 1'h0;
    bor <= 1'h1;
    repeat (20) @(posedge clk);
    chk("stay", 1'h1, ds);
    bor <= 1'h0;
    vbat <= 1'h1;
    alarm <= 1'h1;
    @(posedge clk);
    alarm <= 1'h0;
    up(n);
    chk("pll", 1'h1, n >= 295 && n <= 305);
    rd(8'h08, 32'h4C, 32'h48, "wake");
    rd(8'h30, 32'hFF, 32'h00, "scratch");
  endtask
  task t_master_clear_pin;
    int n;
    wr(8'h18, 32'hC001);
    fw.wr2(8'h34, 32'h3C);
    wr(8'h1C, 32'h0F);
    enter();
    master_clear_pin <= 1'h1;
    @(posedge clk);
    master_clear_pin <= 1'h0;
    up(n);
    chk("xpll", 1'h1, n >= 4390 && n <= 4405);
    chk("released", 8'h00, poe);
    rd(8'h34, 32'hFF, 32'h3C, "scratch");
    rd(8'h08, 32'h54, 32'h04, "wake");
  endtask
  task t_wdt;
    int n, d;
    // a second entry wakes at once if the count was not cleared on entry;
    // pass 1 moves the watchdog to the every-cycle secondary tick
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h18, (i == 0) ? 32'h10 : 32'h2030);
      wr(8'h14, (i == 0) ? 32'h11 : 32'h10);
      secondary_osc <= 1'(i == 1);
      enter();
      chk("low_power_rc_osc", 1'(i == 0), lst);
      chk("secondary_osc", 1'(i == 1), sst);
      chk("ret", 1'h1, ret);
      chk("keep", 1'(i == 0), keep);
      wt(0, 1'h0, n);
      chk("wdt", 1'h1, (i == 0) ? (n >= 120 && n <= 140) : (n >= 60 && n <= 70));
      up(n);
      d = 1 + ((i == 0) ? power_ctrl_pkg::PROG_MEM_CYC : power_ctrl_pkg::RET_START_CYC);
      chk("retdly", d, n);
      rd(8'h08, 32'h10, 32'h10, "wdt");
    end
  endtask
  task t_backup;
    int n;
    wr(8'h1C, 32'h00);
    vdd <= 1'h0;
    repeat (5) @(posedge clk);
    chk("backup", 1'h1, bk);
    chk("reg", 1'h1, ret);
    vdd <= 1'h1;
    up(n);
    rd(8'h10, 32'h3, 32'h1, "exit");
    rd(8'h34, 32'hFF, 32'h3C, "scratch");
    rd(8'h1C, 32'hFF, 32'hFF, "dir");
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h3, 32'h0, "cleared");
    // supply loss with a drained battery: battery back only after the supply
    vdd <= 1'h0;
    vbat <= 1'h0;
    repeat (5) @(posedge clk);
    vdd <= 1'h1;
    @(posedge clk);
    vbat <= 1'h1;
    up(n);
    rd(8'h10, 32'h3, 32'h2, "nobat");
    rd(8'h34, 32'hFF, 32'h00, "drained");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    rd(8'h10, 32'h3, 32'h2, "lost");
    rd(8'h44, 32'hFFFFFFFF, 32'h0, "unmapped");
    wr(8'h10, 32'h0);
    t_pins();
    t_bor();
    t_master_clear_pin();
    t_wdt();
    t_backup();
    print_verdict();
  end
endmodule
